// *** rtl/cstr_pkg.sv ***
package cstr_pkg;
  // status register location and bit positions
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  localparam int BIT_RSV_PAGE = 7;
  localparam int BIT_PAGE_HI = 6;
  localparam int BIT_PAGE_LO = 5;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_PWRDN = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_DC = 1;
  localparam int BIT_CARRY = 0;
  // timer configuration register layout
  localparam int CFG_WIDTH = 6;
  localparam logic [5:0] CFG_RESET = 6'h3F;
  localparam int CFG_SRC = 5;
  localparam int CFG_EDGE = 4;
  localparam int CFG_ASSIGN = 3;
  localparam int CFG_RATE_HI = 2;
  // alu operation classes
  typedef enum logic [2:0] {
    CSTR_OP_NONE = 3'b000,
    CSTR_OP_LOGIC = 3'b001,
    CSTR_OP_ADD = 3'b010,
    CSTR_OP_SUB = 3'b011,
    CSTR_OP_RRF = 3'b100,
    CSTR_OP_RLF = 3'b101
  } cstr_op_e;
endpackage

// *** rtl/cstr_alu_flags.sv ***
`timescale 1ns/1ps
// flag results for one alu operation
module cstr_alu_flags
  import cstr_pkg::*;
(
  // operation
  input wire cstr_op_e op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic [7:0] result,
  input wire logic carry_in,
  // flags
  output logic upd_z,
  output logic upd_dc,
  output logic upd_c,
  output logic new_z,
  output logic new_dc,
  output logic new_c
);
  wire [4:0] low_add = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
  wire [4:0] low_sub = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
  wire [8:0] full_add = {1'b0, opa} + {1'b0, opb};
  wire [8:0] full_sub = {1'b0, opa} - {1'b0, opb};
  wire is_arith = (op == CSTR_OP_ADD) || (op == CSTR_OP_SUB);
  wire is_rot = (op == CSTR_OP_RRF) || (op == CSTR_OP_RLF);

  assign upd_z = is_arith || (op == CSTR_OP_LOGIC);
  assign new_z = (result == 8'h00);
  assign upd_dc = is_arith;
  // subtract reports the inverted borrow
  assign new_dc = (op == CSTR_OP_SUB) ? ~low_sub[4] : low_add[4];
  assign upd_c = is_arith || is_rot;
  assign new_c = (op == CSTR_OP_SUB) ? ~full_sub[8] :
                 (op == CSTR_OP_RRF) ? opa[0] :
                 (op == CSTR_OP_RLF) ? opa[7] :
                 (op == CSTR_OP_ADD) ? full_add[8] : carry_in;
endmodule

// *** rtl/cstr_core_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// - The configuration-load instruction copies the working register into the config register.
// - Every reset sets config bits 5 to 0 to one.
// - The config register keeps six bits only and cannot be read back.
// - Config bit 5 picks the external pin (1) or the instruction clock (0) for the timer.
// - Config bit 4 picks falling (1) or rising (0) edges of the external pin.
// - Config bit 3 gives the prescaler to the watchdog (1) or the timer (0).
// - The rate field gives timer ratios 1:2 to 1:256 and watchdog ratios 1:1 to 1:128.
// - Rotates load carry with the bit shifted out, low bit right and high bit left.
// - Status bits 5 and 6 drive program-counter bits 9 and 10 on jumps and calls.
// - Flag logic wins over a write to zero, digit-carry and carry by a flag-setting op.
// - Timeout and power-down flags ignore writes and change only on their events.
// - Any reset clears the page bits so page zero is selected.
module cstr_core_regs
  import cstr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // reset cause, sampled at the first clock edge after the internal reset is released
  input wire logic por_event,
  // instruction side
  input wire logic [7:0] w_reg,
  input wire logic cfg_load,
  input wire logic file_wr,
  input wire logic [7:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire cstr_op_e alu_op,
  input wire logic [7:0] alu_opa,
  input wire logic [7:0] alu_opb,
  input wire logic [7:0] alu_result,
  input wire logic pc_load,
  // power events
  input wire logic wdt_timeout,
  input wire logic sleep_exec,
  input wire logic wdt_clear_exec,
  // status and page outputs
  output logic [7:0] status_rd,
  output logic [1:0] pc_page,
  output logic pc_page_valid,
  // timer configuration outputs
  output logic tmr_src_ext,
  output logic tmr_edge_fall,
  output logic psc_to_wdt,
  output logic [2:0] psc_rate,
  output logic [7:0] tmr_div_ratio,
  output logic [7:0] wdt_div_ratio
);
  logic [1:0] rst_sync_ff;
  wire rst_core_n = rst_sync_ff[1];
  logic [7:0] status_ff;
  logic [CFG_WIDTH-1:0] cfg_ff;
  logic [1:0] pc_page_ff;
  logic pc_page_valid_ff;
  logic [7:0] tmr_div_ff;
  logic [7:0] wdt_div_ff;
  logic rst_seen_ff;
  logic [7:0] nxt_status;
  logic [CFG_WIDTH-1:0] nxt_cfg;

  function automatic logic [7:0] ratio_of(input logic [2:0] rate, input logic shift_one);
    // four-bit exponent so that code 111 plus one reaches 8 and 1:256 wraps to zero
    ratio_of = 8'h01 << ({1'b0, rate} + {3'b000, shift_one});
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  wire upd_z;
  wire upd_dc;
  wire upd_c;
  wire new_z;
  wire new_dc;
  wire new_c;

  cstr_alu_flags u_flags (
    .op(alu_op),
    .opa(alu_opa),
    .opb(alu_opb),
    .result(alu_result),
    .carry_in(status_ff[BIT_CARRY]),
    .upd_z(upd_z),
    .upd_dc(upd_dc),
    .upd_c(upd_c),
    .new_z(new_z),
    .new_dc(new_dc),
    .new_c(new_c)
  );

  wire status_wr = file_wr && (file_addr == STATUS_ADDR);
  // page bits and reserved bit are plainly writable
  wire [2:0] nxt_page = status_wr ? file_wdata[7:5] : status_ff[7:5];
  // timeout: watchdog timeout clears, clear or sleep sets; writes ignored
  wire nxt_to = wdt_timeout ? 1'b0 :
                (wdt_clear_exec || sleep_exec) ? 1'b1 : status_ff[BIT_TIMEOUT];
  // power-down: sleep clears, watchdog clear sets
  wire nxt_pd = sleep_exec ? 1'b0 :
                wdt_clear_exec ? 1'b1 : status_ff[BIT_PWRDN];
  wire nxt_zf = upd_z ? new_z :
                status_wr ? file_wdata[BIT_ZERO] : status_ff[BIT_ZERO];
  wire nxt_dcf = upd_dc ? new_dc :
                 status_wr ? file_wdata[BIT_DC] : status_ff[BIT_DC];
  wire nxt_cf = upd_c ? new_c :
                status_wr ? file_wdata[BIT_CARRY] : status_ff[BIT_CARRY];

  assign nxt_status = {nxt_page, nxt_to, nxt_pd, nxt_zf, nxt_dcf, nxt_cf};
  assign nxt_cfg = cfg_load ? w_reg[CFG_WIDTH-1:0] : cfg_ff;

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      status_ff <= 8'h18;
      cfg_ff <= CFG_RESET;
      rst_seen_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
      if (!rst_seen_ff && !por_event) begin
        // non-power-up reset: status takes nxt_status exactly as in the power-up branch
        status_ff <= nxt_status;
      end else begin
        status_ff <= nxt_status;
      end
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      pc_page_ff <= 2'b00;
      pc_page_valid_ff <= 1'b0;
      tmr_div_ff <= 8'h00;
      wdt_div_ff <= 8'h00;
    end else begin
      pc_page_ff <= nxt_status[BIT_PAGE_HI:BIT_PAGE_LO];
      pc_page_valid_ff <= pc_load;
      tmr_div_ff <= ratio_of(nxt_cfg[CFG_RATE_HI:0], 1'b1);
      wdt_div_ff <= ratio_of(nxt_cfg[CFG_RATE_HI:0], 1'b0);
    end
  end

  assign status_rd = status_ff;
  assign pc_page = pc_page_ff;
  assign pc_page_valid = pc_page_valid_ff;
  assign tmr_src_ext = cfg_ff[CFG_SRC];
  assign tmr_edge_fall = cfg_ff[CFG_EDGE];
  assign psc_to_wdt = cfg_ff[CFG_ASSIGN];
  assign psc_rate = cfg_ff[CFG_RATE_HI:0];
  assign tmr_div_ratio = tmr_div_ff;
  assign wdt_div_ratio = wdt_div_ff;

  chk_cfg_load_copies: assert property (@(posedge clk) disable iff (!rst_core_n)
    cfg_load |=> cfg_ff == $past(w_reg[CFG_WIDTH-1:0]))
    else $error("config load did not copy w");
  chk_cfg_holds: assert property (@(posedge clk) disable iff (!rst_core_n)
    !cfg_load |=> $stable(cfg_ff))
    else $error("config changed without load");
  chk_cfg_reset_ones: assert property (@(posedge clk)
    $rose(rst_core_n) |-> cfg_ff == CFG_RESET)
    else $error("config not all ones after reset");
  chk_page_reset_zero: assert property (@(posedge clk)
    $rose(rst_core_n) |-> status_ff[7:5] == 3'b000)
    else $error("page bits not cleared by reset");
  chk_flag_wins: assert property (@(posedge clk) disable iff (!rst_core_n)
    (status_wr && upd_z) |=> status_ff[BIT_ZERO] == $past(new_z))
    else $error("status write overrode zero flag");
  chk_to_ignores_write: assert property (@(posedge clk) disable iff (!rst_core_n)
    (!wdt_timeout && !wdt_clear_exec && !sleep_exec) |=> $stable(status_ff[4:3]))
    else $error("timeout or powerdown changed without event");
  chk_sub_carry: assert property (@(posedge clk) disable iff (!rst_core_n)
    (alu_op == CSTR_OP_SUB) |=> status_ff[BIT_CARRY] == ($past(alu_opa) >= $past(alu_opb)))
    else $error("subtract carry not inverted borrow");
  chk_rotate_carry: assert property (@(posedge clk) disable iff (!rst_core_n)
    (alu_op == CSTR_OP_RRF) |=> status_ff[BIT_CARRY] == $past(alu_opa[0]))
    else $error("rotate right carry wrong");
  chk_zero_flag: assert property (@(posedge clk) disable iff (!rst_core_n)
    (alu_op == CSTR_OP_LOGIC) |=> status_ff[BIT_ZERO] == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong");
  chk_page_to_pc: assert property (@(posedge clk) disable iff (!rst_core_n)
    pc_page_valid |-> pc_page == status_ff[6:5])
    else $error("page output differs from status");
  chk_timer_ratio: assert property (@(posedge clk) disable iff (!rst_core_n)
    $stable(cfg_ff) |-> tmr_div_ratio == (wdt_div_ratio << 1))
    else $error("timer ratio not twice watchdog ratio");
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import cstr_pkg::*;
;
  logic clk = 0, rst_n = 0, por_event = 1, cfg_load = 0, file_wr = 0, pc_load = 0;
  logic wdt_timeout = 0, sleep_exec = 0, wdt_clear_exec = 0;
  logic [7:0] w_reg = 0, file_addr = 0, file_wdata = 0, alu_opa = 0, alu_opb = 0, alu_result = 0;
  cstr_op_e alu_op = CSTR_OP_NONE;
  logic [7:0] status_rd, tmr_div_ratio, wdt_div_ratio;
  logic [1:0] pc_page;
  logic [2:0] psc_rate;
  logic pc_page_valid, tmr_src_ext, tmr_edge_fall, psc_to_wdt;
  int errors = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  cstr_core_regs dut (.clk(clk), .rst_n(rst_n), .por_event(por_event), .w_reg(w_reg),
    .cfg_load(cfg_load), .file_wr(file_wr), .file_addr(file_addr), .file_wdata(file_wdata),
    .alu_op(alu_op), .alu_opa(alu_opa), .alu_opb(alu_opb), .alu_result(alu_result),
    .pc_load(pc_load), .wdt_timeout(wdt_timeout), .sleep_exec(sleep_exec),
    .wdt_clear_exec(wdt_clear_exec), .status_rd(status_rd), .pc_page(pc_page),
    .pc_page_valid(pc_page_valid), .tmr_src_ext(tmr_src_ext), .tmr_edge_fall(tmr_edge_fall),
    .psc_to_wdt(psc_to_wdt), .psc_rate(psc_rate), .tmr_div_ratio(tmr_div_ratio),
    .wdt_div_ratio(wdt_div_ratio));
  wire [7:0] cfg_seen = {2'b00, tmr_src_ext, tmr_edge_fall, psc_to_wdt, psc_rate};
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      errors++;
    end
  endtask
  // one request cycle: inputs set after a falling edge are taken at the next rising edge
  task tick;
    @(negedge clk);
    cfg_load = 0;
    file_wr = 0;
    pc_load = 0;
    alu_op = CSTR_OP_NONE;
    wdt_timeout = 0;
    sleep_exec = 0;
    wdt_clear_exec = 0;
  endtask
  task wr_status(input logic [7:0] d, input cstr_op_e o, input logic [7:0] r);
    file_addr = STATUS_ADDR;
    file_wdata = d;
    file_wr = 1;
    alu_op = o;
    alu_result = r;
    tick;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    give_verdict;
  end
  initial begin
    repeat (16) @(negedge clk);
    check("status_rst", status_rd, 8'h18);
    check("cfg_rst", cfg_seen, 8'h3F);
    rst_n = 1;
    repeat (4) @(negedge clk);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      w_reg = 8'hC0 | (i[0] ? 8'h28 : 8'h10) | 8'(i);
      cfg_load = 1;
      tick;
      check("cfg", cfg_seen, {2'b00, w_reg[5:0]});
      tick;
      check("tmr_ratio", tmr_div_ratio, 8'(9'd2 << i));
      check("wdt_ratio", wdt_div_ratio, 8'(1 << i));
    end
    $display("test config done");
    wr_status(8'hFF, CSTR_OP_NONE, 8'h00);
    check("st_ff", status_rd, 8'hFF);
    pc_load = 1;
    tick;
    check("page", {6'h00, pc_page}, 8'h03);
    check("page_vld", {7'h00, pc_page_valid}, 8'h01);
    alu_opa = 8'h0F;
    alu_opb = 8'h01;
    wr_status(8'h00, CSTR_OP_ADD, 8'h10);
    check("st_add", status_rd, 8'h1A);
    file_addr = 8'h04;
    file_wr = 1;
    file_wdata = 8'hFF;
    tick;
    check("st_other", status_rd, 8'h1A);
    alu_opa = 8'h33;
    alu_opb = 8'h33;
    alu_result = 8'h00;
    alu_op = CSTR_OP_SUB;
    tick;
    check("st_sub", status_rd, 8'h1F);
    alu_opa = 8'h02;
    alu_op = CSTR_OP_RRF;
    tick;
    check("st_rrf", status_rd, 8'h1E);
    alu_opa = 8'h80;
    alu_op = CSTR_OP_RLF;
    tick;
    check("st_rlf", status_rd, 8'h1F);
    wr_status(8'h00, CSTR_OP_LOGIC, 8'h00);
    check("st_logic", status_rd, 8'h1C);
    $display("test status done");
    wdt_timeout = 1;
    tick;
    check("st_wdt", status_rd, 8'h0C);
    wr_status(8'hFF, CSTR_OP_NONE, 8'h00);
    check("st_wr_to", status_rd, 8'hEF);
    sleep_exec = 1;
    tick;
    check("st_sleep", status_rd, 8'hF7);
    wdt_clear_exec = 1;
    tick;
    check("st_clr", status_rd, 8'hFF);
    rst_n = 0;
    tick;
    check("status_rst2", status_rd, 8'h18);
    check("cfg_rst2", cfg_seen, 8'h3F);
    check("page_rst2", {6'h00, pc_page}, 8'h00);
    $display("test events done");
    give_verdict;
  end
endmodule
